// File: common/arb_pkg.sv
// constants for the data memory bus arbiter
package arb_pkg;
  // ************************************************************
  // masters and priority setting
  // ************************************************************
  localparam int          NUM_MASTERS   = 3;
  localparam int          MST_CORE      = 0;
  localparam int          MST_DMA       = 1;
  localparam int          MST_DEBUG     = 2;
  localparam logic [15:0] PRIO_DEFAULT  = 16'h0000;
  localparam logic [15:0] PRIO_DMA_HIGH = 16'h0020;
  localparam logic [15:0] PRIO_RESET    = 16'h0000;
  // priority levels: 0 highest, 4 lowest
  localparam logic [2:0]  PRIORITY_LEVEL_ZERO  = 3'h0;
  localparam logic [2:0]  PRIORITY_LEVEL_ONE   = 3'h1;
  localparam logic [2:0]  PRIORITY_LEVEL_TWO   = 3'h2;
  localparam logic [2:0]  PRIORITY_LEVEL_THREE = 3'h3;
  localparam logic [2:0]  PRIORITY_LEVEL_FOUR  = 3'h4;
  // arbiter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } arb_state_t;
endpackage : arb_pkg

// File: rtl/data_memory_bus_arbiter.sv
// fixed priority arbiter for data memory and extended data space
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1: arbitrate data memory and extended space among core, dma, debugger.
// RQ2: grant only the top requester; losers wait until it completes.
// RQ3: default order is core level zero, dma level three, debugger four.
// RQ4: levels one and two hold no master by default.
// RQ5: priority setting moves dma above or below the core.
// RQ6: raised masters keep relative order, lower level wins.
// RQ7: masters left below the core keep their relative order.
// RQ8: 0x0000 core,dma,debugger; 0x0020 dma,core at level one,debugger.
// RQ9: software writes only the two defined setting values.
// RQ10: setting may change anytime; next decision uses new order.
// RQ11: one grant per cycle; reset selects default core-first order.
module data_memory_bus_arbiter
  import arb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] bus_master_priority_setting,
  input  wire logic [2:0]  req,
  input  wire logic [2:0]  done,
  output logic      [2:0]  gnt,
  output logic             busy
);
  // ************************************************************
  // setting register
  // ************************************************************
  logic [15:0] setting_ff;
  logic [15:0] nxt_setting;
  // sample setting every cycle, reset to default
  always_comb
  begin
    nxt_setting = bus_master_priority_setting; // RQ10
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      setting_ff <= PRIO_RESET; // RQ11
    else
      setting_ff <= nxt_setting;
  end

  // ************************************************************
  // levels per master
  // ************************************************************
  logic [2:0] lvl_core;
  logic [2:0] lvl_dma;
  logic [2:0] lvl_dbg;
  prio_rank #(
    .LEVEL_DEFAULT (PRIORITY_LEVEL_ZERO),
    .LEVEL_RAISED  (PRIORITY_LEVEL_ONE) // RQ8
  ) u_rank_core (
    .setting (setting_ff),
    .level   (lvl_core)
  );
  prio_rank #(
    .LEVEL_DEFAULT (PRIORITY_LEVEL_THREE), // RQ4
    .LEVEL_RAISED  (PRIORITY_LEVEL_ZERO)
  ) u_rank_dma (
    .setting (setting_ff),
    .level   (lvl_dma)
  );
  prio_rank #(
    .LEVEL_DEFAULT (PRIORITY_LEVEL_FOUR),
    .LEVEL_RAISED  (PRIORITY_LEVEL_FOUR)
  ) u_rank_dbg (
    .setting (setting_ff),
    .level   (lvl_dbg)
  );

  // ************************************************************
  // winner select
  // ************************************************************
  logic [2:0] pick;
  logic [2:0] best;
  // lowest level among requesters wins
  always_comb
  begin
    pick = 3'h0;
    best = 3'h7;
    if (req[MST_DEBUG] && lvl_dbg < best) // RQ7
    begin
      pick = 3'h4;
      best = lvl_dbg;
    end
    if (req[MST_DMA] && lvl_dma < best) // RQ6
    begin
      pick = 3'h2;
      best = lvl_dma;
    end
    if (req[MST_CORE] && lvl_core < best) // RQ3
    begin
      pick = 3'h1;
      best = lvl_core;
    end
  end

  // ************************************************************
  // grant state machine
  // ************************************************************
  arb_state_t state_ff;
  arb_state_t nxt_state;
  logic [2:0] gnt_ff;
  logic [2:0] nxt_gnt;
  // hold grant until owner signals done; others wait
  always_comb
  begin
    nxt_state = state_ff;
    nxt_gnt   = gnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (|pick) // RQ1
        begin
          nxt_gnt   = pick; // RQ2
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (|(done & gnt_ff)) // RQ2
        begin
          nxt_gnt   = 3'h0;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_gnt   = 3'h0;
        nxt_state = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      gnt_ff   <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      gnt_ff   <= nxt_gnt;
    end
  end
  assign gnt  = gnt_ff;
  assign busy = state_ff[1];

  // ************************************************************
  // checks
  // ************************************************************
  property p_onehot;
    @(posedge clk) disable iff (rst) $onehot0(gnt_ff);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two grants"); // RQ11
  property p_hold;
    @(posedge clk) disable iff (rst)
      (busy && !(|(done & gnt_ff))) |=> $stable(gnt_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("grant dropped"); // RQ2
  property p_core_first;
    @(posedge clk) disable iff (rst)
      (!busy && req[MST_CORE] && setting_ff != PRIO_DMA_HIGH)
      |=> gnt_ff == 3'h1;
  endproperty
  a_core_first: assert property (p_core_first) // RQ8
    else $error("core lost by default");
  property p_dma_first;
    @(posedge clk) disable iff (rst)
      (!busy && req[MST_DMA] && setting_ff == PRIO_DMA_HIGH)
      |=> gnt_ff == 3'h2;
  endproperty
  a_dma_first: assert property (p_dma_first) // RQ5
    else $error("dma lost when raised");
  property p_dma_over_dbg;
    @(posedge clk) disable iff (rst)
      (!busy && req == 3'h6) |=> gnt_ff == 3'h2;
  endproperty
  a_dma_over_dbg: assert property (p_dma_over_dbg) // RQ7
    else $error("debugger beat dma");
  property p_release;
    @(posedge clk) disable iff (rst)
      (busy && |(done & gnt_ff)) |=> (!busy && gnt_ff == 3'h0);
  endproperty
  a_release: assert property (p_release) // RQ2
    else $error("no release");
  property p_reset_default;
    @(posedge clk) $fell(rst) |-> setting_ff == PRIO_RESET;
  endproperty
  a_reset_default: assert property (p_reset_default) // RQ11
    else $error("bad reset order");
  // a request seen while idle is granted on the next edge
  sequence s_taken;
    !busy && (req != 3'h0);
  endsequence
  sequence s_granted;
    busy && (gnt_ff != 3'h0) && ((gnt_ff & ~$past(req)) == 3'h0);
  endsequence
  property p_grant_next;
    @(posedge clk) disable iff (rst) s_taken |=> s_granted;
  endproperty
  a_grant_next: assert property (p_grant_next) // RQ1
    else $error("request not granted");
  // default order keeps the reserved levels empty
  property p_no_reserved_level;
    @(posedge clk) disable iff (rst)
      (setting_ff != PRIO_DMA_HIGH) |->
        (lvl_core == PRIORITY_LEVEL_ZERO)
        && (lvl_dma == PRIORITY_LEVEL_THREE)
        && (lvl_dbg == PRIORITY_LEVEL_FOUR);
  endproperty
  a_no_reserved_level: assert property (p_no_reserved_level) // RQ4
    else $error("default order uses a reserved level");
  // raised order puts dma on top and core one level down
  property p_raised_levels;
    @(posedge clk) disable iff (rst)
      (setting_ff == PRIO_DMA_HIGH) |->
        (lvl_dma == PRIORITY_LEVEL_ZERO)
        && (lvl_core == PRIORITY_LEVEL_ONE)
        && (lvl_dbg == PRIORITY_LEVEL_FOUR);
  endproperty
  a_raised_levels: assert property (p_raised_levels) // RQ8
    else $error("raised order levels wrong");
  // a new setting is in force one edge after it is sampled
  property p_setting_follows;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> setting_ff == $past(bus_master_priority_setting);
  endproperty
  a_setting_follows: assert property (p_setting_follows) // RQ10
    else $error("setting not taken");
  // busy flag and grant vector agree
  property p_busy_grant;
    @(posedge clk) disable iff (rst) busy == (gnt_ff != 3'h0);
  endproperty
  a_busy_grant: assert property (p_busy_grant) // RQ11
    else $error("busy and grant disagree");
endmodule : data_memory_bus_arbiter
`default_nettype wire

// File: rtl/prio_rank.sv
// level table for one master from the priority setting
`timescale 1ns/1ps
`default_nettype none
module prio_rank
  import arb_pkg::*;
#(
  parameter logic [2:0] LEVEL_DEFAULT = 3'h0,
  parameter logic [2:0] LEVEL_RAISED  = 3'h0
)(
  input  wire logic [15:0] setting,
  output logic      [2:0]  level
);
  // ************************************************************
  // level select
  // ************************************************************
  // anything but the raised value ranks as default
  always_comb
  begin
    if (setting == PRIO_DMA_HIGH) // RQ5
      level = LEVEL_RAISED;
    else
      level = LEVEL_DEFAULT;
  end
endmodule : prio_rank
`default_nettype wire

// File: testbench/bus_masters.sv
// model of the core, dma and debugger masters
`timescale 1ns/1ps
`default_nettype none
module bus_masters (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  input  wire logic [2:0] gnt,
  output logic      [2:0] req,
  output logic      [2:0] done
);
  logic [2:0] pend_ff = 3'h0;
  logic [2:0] done_ff = 3'h0;
  // a request stays up until it is granted
  assign req  = pend_ff | want;
  assign done = done_ff;
  // latch on the edge so the bench can drop want at the falling edge
  always @(posedge clk)
  begin
    pend_ff <= (pend_ff | want) & ~gnt;
  end
  // done after a prompt or slow hold, one pulse
  always @(negedge clk)
  begin
    done_ff <= gnt & ~done_ff & {3{1'($urandom_range(1, 0))}};
  end
endmodule : bus_masters
`default_nettype wire

// File: testbench/data_memory_bus_arbiter_tb_top.sv
// self-checking bench for the data memory bus arbiter
`timescale 1ns/1ps
`default_nettype none
module data_memory_bus_arbiter_tb_top;
  import arb_pkg::*;
  logic        clk, rst, busy;
  logic [15:0] setting, s;
  logic [2:0]  want, req, done, gnt, gnt_q, m;
  logic [2:0]  expq[$];
  int          mismatches, comparisons;
  data_memory_bus_arbiter data_memory_bus_arbiter_inst (.clk(clk),
    .rst(rst), .bus_master_priority_setting(setting), .req(req),
    .done(done), .gnt(gnt), .busy(busy));
  bus_masters bus_masters_inst (.clk(clk), .want(want), .gnt(gnt),
    .req(req), .done(done));
  // ***********
  // clock and helpers
  // ***********
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // note the grant order of a request set
  task automatic note_order(input logic [15:0] v, input logic [2:0] r);
    int idx;
    for (int k = 0; k < 3; k++)
    begin
      idx = (k == 2) ? MST_DEBUG
          : ((k == 0) == (v == PRIO_DMA_HIGH)) ? MST_DMA : MST_CORE;
      if (r[idx])
        expq.push_back(3'h1 << idx);
    end
  endtask : note_order
  task automatic wait_idle();
    int n;
    n = 0;
    while ((expq.size() != 0 || busy !== 1'b0) && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    check(3'(expq.size()), 3'h0);
  endtask : wait_idle
  // compare each new grant with the oldest note
  always @(posedge clk)
  begin
    #1;
    if (gnt !== gnt_q && gnt !== 3'h0)
    begin
      check(gnt, expq.size() ? expq.pop_front() : 3'h0);
      check({2'h0, busy}, 3'h1);
    end
    gnt_q = gnt;
  end
  // ***********
  // main sequence
  // ***********
  initial
  begin
    void'($urandom(32'h2e4a5226));
    rst = 1'b1;
    want = 3'h0;
    setting = PRIO_DMA_HIGH;
    gnt_q = 3'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    want = 3'b011;
    note_order(PRIO_RESET, 3'b011);
    @(negedge clk);
    want = 3'h0;
    wait_idle();
    for (int i = 0; i < 24; i++)
    begin
      // only the two defined setting values are written
      s = (i % 3 == 1) ? PRIO_DMA_HIGH : PRIO_DEFAULT;
      if (i % 3 == 2)
        s = $urandom_range(1, 0) ? PRIO_DMA_HIGH : PRIO_DEFAULT;
      setting = s;
      @(negedge clk);
      m = (i < 6) ? 3'h7 : 3'($urandom_range(7, 1));
      want = m;
      note_order(s, m);
      @(negedge clk);
      want = 3'h0;
      wait_idle();
    end
    finish_test();
  end
  // cut a hang short
  initial
  begin
    #(8 * 5000);
    mismatches++;
    finish_test();
  end
endmodule : data_memory_bus_arbiter_tb_top
`default_nettype wire
